// ### hw/rxa_pkg.sv
// constants for the receive alarm and section receiver control bank
package rxa_pkg;
   // -------------------------------------------------------------------
   // register bus
   // -------------------------------------------------------------------
   localparam int ADDR_W = 8;
   localparam int DATA_W = 8;
   localparam logic [7:0] OFS_LINE_AIS = 8'h0c;
   localparam logic [7:0] OFS_PATH_AIS = 8'h0d;
   localparam logic [7:0] OFS_ROUTE1 = 8'h0e;
   localparam logic [7:0] OFS_ROUTE2 = 8'h0f;
   localparam logic [7:0] OFS_SEC_CTRL = 8'h10;
   localparam logic [7:0] OFS_SEC_STAT = 8'h11;
   // -------------------------------------------------------------------
   // reset values
   // -------------------------------------------------------------------
   localparam logic [7:0] RST_LINE_AIS = 8'h30;
   localparam logic [7:0] RST_PATH_AIS = 8'hff;
   localparam logic [7:0] RST_ROUTE = 8'h00;
   localparam logic [7:0] RST_SEC_CTRL = 8'h00;
   // -------------------------------------------------------------------
   // field positions
   // -------------------------------------------------------------------
   localparam int B_LOSINS = 4;
   localparam int B_FRAME_LOSS_AIS_INSERT_EN = 5;
   localparam int B_SIGNAL_FAIL_AIS_INSERT_EN = 6;
   localparam int B_SIGNAL_DEGRADE_AIS_INSERT_EN = 7;
   localparam int B_LOP_AIS = 3;
   localparam int B_LOPCON_AIS = 6;
   localparam int B_PAISCON_AIS = 7;
   localparam int B_OOF_IE = 0;
   localparam int B_LOF_IE = 1;
   localparam int B_LOS_IE = 2;
   localparam int B_BIP_IE = 3;
   localparam int B_ALT_FR = 4;
   localparam int B_FORCE_OUT_OF_FRAME = 5;
   localparam int B_DDS = 6;
   localparam int B_BLK = 7;
   // status: live bits 2..0, sticky bits 6..3, bit 7 unused
   localparam int B_LIVE_LSB = 0;
   localparam int B_STICKY_LSB = 3;
   localparam int N_LIVE = 3;
   localparam int N_STICKY = 4;
   // -------------------------------------------------------------------
   // framing patterns
   // -------------------------------------------------------------------
   localparam logic [7:0] A1_PATTERN = 8'hf6;
   localparam logic [7:0] A2_PATTERN = 8'h28;
   localparam logic [7:0] MASK_FULL = 8'hff;
   localparam logic [7:0] MASK_NIBBLE = 8'hf0;
endpackage

// ### hw/rxa_alarm_section_ctrl.sv
// receive alarm control and section receiver control/status bank
//
// The implementer's own choice: the plain strobed port.
`timescale 1ns/100ps
module rxa_alarm_section_ctrl
   import rxa_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // register port
   input wire logic [ADDR_W-1:0] reg_addr,
   input wire logic [DATA_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [DATA_W-1:0] reg_rdata,
   // line and path alarm states
   input wire logic signal_loss_in,
   input wire logic frame_loss_in,
   input wire logic out_of_frame_in,
   input wire logic line_ais_in,
   input wire logic line_rdi_in,
   input wire logic degrade_ber_in,
   input wire logic fail_ber_in,
   input wire logic pointer_loss_in,
   input wire logic cell_delin_loss_in,
   input wire logic path_ais_in,
   input wire logic path_rdi_in,
   input wire logic path_enh_rdi_in,
   input wire logic label_mismatch_in,
   input wire logic concat_violation_in,
   input wire logic concat_pointer_loss_in,
   input wire logic concat_path_ais_in,
   // section parity check, one pulse per frame
   input wire logic b1_check_vld,
   input wire logic [7:0] b1_err_bits,
   // framing bytes
   input wire logic frame_boundary,
   input wire logic fr_byte_vld,
   input wire logic [7:0] fr_byte,
   input wire logic fr_first_a1,
   input wire logic fr_is_a2,
   input wire logic fr_last_a2,
   // receive data stream
   input wire logic rx_in_vld,
   input wire logic [7:0] rx_in_data,
   input wire logic [7:0] scr_keystream,
   // outputs
   output logic path_ais_insert,
   output logic force_cell_delin_loss,
   output logic alarm_summary_output,
   output logic section_irq,
   output logic force_oof_pulse,
   output logic alt_framing_select,
   output logic descrambler_bypass,
   output logic block_parity_count,
   output logic b1_inc_vld,
   output logic [3:0] b1_inc,
   output logic fr_check_done,
   output logic fr_pattern_ok,
   output logic rx_out_vld,
   output logic [7:0] rx_out_data
);

   // -------------------------------------------------------------------
   // state
   // -------------------------------------------------------------------
   typedef struct packed {
      logic [7:0] line_ais;
      logic [7:0] path_ais;
      logic [7:0] route1;
      logic [7:0] route2;
      logic [7:0] ctrl;
      logic [N_STICKY-1:0] sticky;
      logic [N_LIVE-1:0] live;
      logic force_out_of_frame_pend;
      logic force_oof;
      logic ais;
      logic lcd;
      logic summary;
      logic irq;
      logic [7:0] rd_data;
      logic b1_vld;
      logic [3:0] b1_inc;
      logic fr_miss;
      logic fr_done;
      logic fr_ok;
      logic rx_vld;
      logic [7:0] rx_data;
   } rxa_state_t;

   localparam rxa_state_t ST_RST = '{
      line_ais: RST_LINE_AIS,
      path_ais: RST_PATH_AIS,
      route1: RST_ROUTE,
      route2: RST_ROUTE,
      ctrl: RST_SEC_CTRL,
      default: '0
   };

   rxa_state_t r_q;
   rxa_state_t r_d;

   // -------------------------------------------------------------------
   // combinational helpers
   // -------------------------------------------------------------------
   logic [N_LIVE-1:0] live_now;
   logic [15:0] alarm_vec;
   logic [15:0] route_en;
   logic ais_cause;
   logic [3:0] bit_cnt;
   logic fr_examined;
   logic fr_mism;
   logic [7:0] fr_expect;
   logic [7:0] fr_mask;
   logic wr_ctrl;
   logic rd_stat;
   logic b1_err;

   assign live_now = {signal_loss_in, frame_loss_in, out_of_frame_in};
   // vector positions match the route enable bit order, reserved slots zero
   assign alarm_vec = {1'b0, fail_ber_in, degrade_ber_in, line_rdi_in,
                       line_ais_in, out_of_frame_in, frame_loss_in,
                       signal_loss_in, concat_violation_in, 1'b0,
                       label_mismatch_in, path_enh_rdi_in, path_rdi_in,
                       path_ais_in, cell_delin_loss_in, pointer_loss_in};
   assign route_en = {r_q.route2, r_q.route1};
   assign wr_ctrl = reg_wr && (reg_addr == OFS_SEC_CTRL);
   assign rd_stat = reg_rd && (reg_addr == OFS_SEC_STAT);
   assign b1_err = b1_check_vld && (|b1_err_bits);

   always_comb
   begin
      ais_cause = (signal_loss_in && r_q.line_ais[B_LOSINS])
         || (frame_loss_in && r_q.line_ais[B_FRAME_LOSS_AIS_INSERT_EN])
         || (fail_ber_in && r_q.line_ais[B_SIGNAL_FAIL_AIS_INSERT_EN])
         || (degrade_ber_in && r_q.line_ais[B_SIGNAL_DEGRADE_AIS_INSERT_EN])
         || (pointer_loss_in && r_q.path_ais[B_LOP_AIS])
         || (concat_pointer_loss_in && r_q.path_ais[B_LOPCON_AIS])
         || (concat_path_ais_in && r_q.path_ais[B_PAISCON_AIS]);
   end

   // errored bits of one B1 byte
   always_comb
   begin
      bit_cnt = 4'h0;
      for (int i = 0; i < 8; i++)
      begin
         bit_cnt = bit_cnt + 4'(b1_err_bits[i]);
      end
   end

   // framing pattern compare
   always_comb
   begin
      fr_expect = fr_is_a2 ? A2_PATTERN : A1_PATTERN;
      fr_mask = MASK_FULL;
      fr_examined = 1'b1;
      if (r_q.ctrl[B_ALT_FR])
      begin
         // only 12 bits count, the rest of the pattern is ignored
         fr_examined = fr_first_a1 || fr_last_a2;
         fr_mask = fr_last_a2 ? MASK_NIBBLE : MASK_FULL;
      end
      fr_mism = fr_examined && (|((fr_byte ^ fr_expect) & fr_mask));
   end

   // -------------------------------------------------------------------
   // next state
   // -------------------------------------------------------------------
   always_comb
   begin
      r_d = r_q;
      // register writes; reserved bits are kept as written
      if (reg_wr)
      begin
         case (reg_addr)
            OFS_LINE_AIS: r_d.line_ais = reg_wdata;
            OFS_PATH_AIS: r_d.path_ais = reg_wdata;
            OFS_ROUTE1: r_d.route1 = reg_wdata;
            OFS_ROUTE2: r_d.route2 = reg_wdata;
            OFS_SEC_CTRL: r_d.ctrl = reg_wdata & ~(8'h01 << B_FORCE_OUT_OF_FRAME);
            default: r_d.ctrl = r_q.ctrl;
         endcase
      end

      // force out of frame waits for the frame boundary
      r_d.force_oof = r_q.force_out_of_frame_pend && frame_boundary;
      r_d.force_out_of_frame_pend = (r_q.force_out_of_frame_pend && !frame_boundary)
         || (wr_ctrl && reg_wdata[B_FORCE_OUT_OF_FRAME]);

      // automatic path AIS and the cell delineation loss it forces
      r_d.ais = ais_cause;
      r_d.lcd = ais_cause;

      r_d.summary = |(alarm_vec & route_en);

      // sticky status: set wins over the clear of a status read
      r_d.live = live_now;
      if (rd_stat)
      begin
         r_d.sticky = '0;
      end
      r_d.sticky[0] = r_d.sticky[0] || (live_now[0] ^ r_q.live[0]);
      r_d.sticky[1] = r_d.sticky[1] || (live_now[1] ^ r_q.live[1]);
      r_d.sticky[2] = r_d.sticky[2] || (live_now[2] ^ r_q.live[2]);
      r_d.sticky[3] = r_d.sticky[3] || b1_err;

      // interrupt from next sticky and next enables, so it tracks the flops
      r_d.irq = |(r_d.sticky
         & r_d.ctrl[B_BIP_IE:B_OOF_IE]);

      // read data, one cycle after the strobe; unmapped reads zero
      r_d.rd_data = 8'h00;
      if (reg_rd)
      begin
         case (reg_addr)
            OFS_LINE_AIS: r_d.rd_data = r_q.line_ais;
            OFS_PATH_AIS: r_d.rd_data = r_q.path_ais;
            OFS_ROUTE1: r_d.rd_data = r_q.route1;
            OFS_ROUTE2: r_d.rd_data = r_q.route2;
            OFS_SEC_CTRL: r_d.rd_data = r_q.ctrl;
            OFS_SEC_STAT: r_d.rd_data = {1'b0, r_q.sticky, r_q.live};
            default: r_d.rd_data = 8'h00;
         endcase
      end

      // B1 error count increment
      r_d.b1_vld = b1_check_vld;
      r_d.b1_inc = 4'h0;
      if (b1_check_vld)
      begin
         r_d.b1_inc = r_q.ctrl[B_BLK] ? {3'h0, b1_err} : bit_cnt;
      end

      // framing check accumulates over one A1/A2 group
      r_d.fr_done = 1'b0;
      if (fr_byte_vld)
      begin
         r_d.fr_miss = fr_first_a1 ? fr_mism : (r_q.fr_miss || fr_mism);
         if (fr_last_a2)
         begin
            r_d.fr_done = 1'b1;
            r_d.fr_ok = !(r_q.fr_miss || fr_mism);
         end
      end

      // descrambler, bypassed on request
      r_d.rx_vld = rx_in_vld;
      if (rx_in_vld)
      begin
         r_d.rx_data = r_q.ctrl[B_DDS] ? rx_in_data
            : (rx_in_data ^ scr_keystream);
      end
   end

   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         r_q <= ST_RST;
      end
      else
      begin
         r_q <= r_d;
      end
   end

   // -------------------------------------------------------------------
   // outputs
   // -------------------------------------------------------------------
   assign reg_rdata = r_q.rd_data;
   assign path_ais_insert = r_q.ais;
   assign force_cell_delin_loss = r_q.lcd;
   assign alarm_summary_output = r_q.summary;
   assign section_irq = r_q.irq;
   assign force_oof_pulse = r_q.force_oof;
   assign alt_framing_select = r_q.ctrl[B_ALT_FR];
   assign descrambler_bypass = r_q.ctrl[B_DDS];
   assign block_parity_count = r_q.ctrl[B_BLK];
   assign b1_inc_vld = r_q.b1_vld;
   assign b1_inc = r_q.b1_inc;
   assign fr_check_done = r_q.fr_done;
   assign fr_pattern_ok = r_q.fr_ok;
   assign rx_out_vld = r_q.rx_vld;
   assign rx_out_data = r_q.rx_data;

   // -------------------------------------------------------------------
   // assertions
   // -------------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   a_ais_frame_loss: assert property (
      frame_loss_in && r_q.line_ais[B_FRAME_LOSS_AIS_INSERT_EN] |=> path_ais_insert)
      else $error("frame loss did not insert path AIS");

   a_ais_fail: assert property (
      fail_ber_in && r_q.line_ais[B_SIGNAL_FAIL_AIS_INSERT_EN] |=> path_ais_insert)
      else $error("signal fail did not insert path AIS");

   a_ais_degrade: assert property (
      degrade_ber_in && r_q.line_ais[B_SIGNAL_DEGRADE_AIS_INSERT_EN] |=> path_ais_insert)
      else $error("signal degrade did not insert path AIS");

   a_ais_ptr_masked: assert property (
      pointer_loss_in && !r_q.path_ais[B_LOP_AIS] && !signal_loss_in
      && !frame_loss_in && !fail_ber_in && !degrade_ber_in
      && !concat_pointer_loss_in && !concat_path_ais_in
      |=> !path_ais_insert)
      else $error("masked pointer loss asserted path AIS");

   a_ais_concat: assert property (
      (concat_pointer_loss_in && r_q.path_ais[B_LOPCON_AIS])
      || (concat_path_ais_in && r_q.path_ais[B_PAISCON_AIS])
      |=> path_ais_insert)
      else $error("concatenation event did not insert path AIS");

   a_lcd_tracks: assert property (
      force_cell_delin_loss == path_ais_insert)
      else $error("cell delineation loss not tied to path AIS");

   a_summary_mask: assert property (
      ((alarm_vec & route_en) == 16'h0000) |=> !alarm_summary_output)
      else $error("disabled alarm reached summary output");

   a_summary_set: assert property (
      (|(alarm_vec & route_en)) |=> alarm_summary_output)
      else $error("enabled alarm missing from summary output");

   a_oof_change: assert property (
      $changed(out_of_frame_in) |=> r_q.sticky[0] [*1] ##1 1'b1)
      else $error("out-of-frame change not latched");

   a_bip_sticky: assert property (
      b1_err && r_q.ctrl[B_BIP_IE]
      && !(wr_ctrl && !reg_wdata[B_BIP_IE])
      |=> r_q.sticky[3] && section_irq)
      else $error("B1 error did not raise its interrupt");

   a_irq_gate: assert property (
      section_irq == (|(r_q.sticky & r_q.ctrl[B_BIP_IE:B_OOF_IE])))
      else $error("interrupt output disagrees with enabled status");

   a_read_clear: assert property (
      rd_stat && !b1_err && (live_now == r_q.live)
      |=> r_q.sticky == 4'h0)
      else $error("status read did not clear sticky bits");

   a_live_read: assert property (
      rd_stat |=> reg_rdata[2:0] == $past(r_q.live))
      else $error("live state bits read wrong");

   a_force_out_of_frame_boundary: assert property (
      wr_ctrl && reg_wdata[B_FORCE_OUT_OF_FRAME] ##1 !frame_boundary [*2]
      |=> !force_oof_pulse)
      else $error("force out of frame fired without boundary");

   a_force_out_of_frame_fires: assert property (
      wr_ctrl && reg_wdata[B_FORCE_OUT_OF_FRAME] ##1 frame_boundary
      |=> force_oof_pulse)
      else $error("force out of frame missed its boundary");

   a_block_count: assert property (
      b1_err && r_q.ctrl[B_BLK] |=> b1_inc == 4'h1)
      else $error("block parity count not one");

   c_ais_on: cover property (!path_ais_insert ##1 path_ais_insert);
   c_summary_on: cover property (alarm_summary_output);
   c_irq_clear: cover property (section_irq ##1 rd_stat ##2 !section_irq);
   c_force_oof: cover property (force_oof_pulse);

endmodule // rxa_alarm_section_ctrl

// ### testbench/rxa_line_model.sv
// line-side model that sends one framing header per request
`timescale 1ns/100ps
module rxa_line_model
   import rxa_pkg::*;
(
   // clock and request
   input wire logic clk,
   input wire logic go,
   // byte to corrupt and its error pattern
   input wire logic [2:0] bad_idx,
   input wire logic [7:0] bad_xor,
   // framing byte stream
   output logic frame_boundary,
   output logic fr_byte_vld,
   output logic [7:0] fr_byte,
   output logic fr_first_a1,
   output logic fr_is_a2,
   output logic fr_last_a2
);
   // ------------------------------------------------------------------
   // three A1 bytes then three A2 bytes, one byte a cycle
   // ------------------------------------------------------------------
   initial
   begin
      frame_boundary = 1'h0;
      fr_byte_vld = 1'h0;
      fr_byte = 8'h00;
      fr_first_a1 = 1'h0;
      fr_is_a2 = 1'h0;
      fr_last_a2 = 1'h0;
   end
   always @(posedge clk)
   begin
      if (go)
      begin
         for (int i = 0; i < 6; i++)
         begin
            fr_byte_vld <= 1'h1;
            frame_boundary <= (i == 0);
            fr_first_a1 <= (i == 0);
            fr_is_a2 <= (i > 2);
            fr_last_a2 <= (i == 5);
            fr_byte <= ((i > 2) ? A2_PATTERN : A1_PATTERN) ^
               ((i == bad_idx) ? bad_xor : 8'h00);
            @(posedge clk);
         end
         fr_byte_vld <= 1'h0;
         frame_boundary <= 1'h0;
         fr_first_a1 <= 1'h0;
         fr_is_a2 <= 1'h0;
         fr_last_a2 <= 1'h0;
         // idle line must not look like a held byte
         fr_byte <= ~fr_byte;
      end
   end
endmodule // rxa_line_model

// ### testbench/rxa_alarm_section_ctrl_bench.sv
// self-checking bench for the receive alarm and section control bank
`timescale 1ns/100ps
module rxa_alarm_section_ctrl_bench
   import rxa_pkg::*;
   ;
   // ------------------------------------------------------------------
   // signals
   // ------------------------------------------------------------------
   logic clk, sys_rst, reg_wr, reg_rd, b1_check_vld, frame_boundary;
   logic fb_b, fb_m, rx_in_vld, fr_byte_vld, fr_first_a1, fr_is_a2;
   logic fr_last_a2, fr_go, path_ais_insert, force_cell_delin_loss;
   logic alarm_summary_output, section_irq, force_oof_pulse;
   logic alt_framing_select, descrambler_bypass, block_parity_count;
   logic b1_inc_vld, fr_check_done, fr_pattern_ok, rx_out_vld;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, b1_err_bits, rx_in_data;
   logic [7:0] scr_keystream, rx_out_data, fr_byte, bad_xor;
   logic [3:0] b1_inc;
   logic [2:0] bad_idx;
   logic [15:0] al;
   logic signal_loss_in, frame_loss_in, out_of_frame_in, line_ais_in;
   logic line_rdi_in, degrade_ber_in, fail_ber_in, pointer_loss_in;
   logic cell_delin_loss_in, path_ais_in, path_rdi_in, path_enh_rdi_in;
   logic label_mismatch_in, concat_violation_in, concat_pointer_loss_in;
   logic concat_path_ais_in;
   int fail_count = 0;
   int checks_done = 0;
   localparam int SRC [6] = '{1, 6, 5, 7, 14, 15};
   localparam logic [7:0] B1_CTL [4] = '{8'h08, 8'h08, 8'h88, 8'h88};
   localparam logic [7:0] B1_ERR [4] = '{8'h05, 8'hff, 8'h05, 8'hff};
   localparam logic [3:0] B1_INC [4] = '{4'h2, 4'h8, 4'h1, 4'h1};
   localparam logic [7:0] FR_CTL [8] = '{8'h00, 8'h00, 8'h10, 8'h10,
      8'h10, 8'h10, 8'h10, 8'h00};
   localparam logic [2:0] FR_IDX [8] = '{3'h7, 3'h1, 3'h1, 3'h4, 3'h5,
      3'h5, 3'h0, 3'h5};
   localparam logic [7:0] FR_XOR [8] = '{8'h00, 8'h01, 8'h01, 8'h80,
      8'h01, 8'h10, 8'h80, 8'h01};
   localparam logic FR_OK [8] = '{1'h1, 1'h0, 1'h1, 1'h1, 1'h1, 1'h0,
      1'h0, 1'h0};
   assign frame_boundary = fb_b | fb_m;
   assign {concat_path_ais_in, concat_pointer_loss_in, concat_violation_in,
      label_mismatch_in, path_enh_rdi_in, path_rdi_in, path_ais_in,
      cell_delin_loss_in, pointer_loss_in, fail_ber_in, degrade_ber_in,
      line_rdi_in, line_ais_in, out_of_frame_in, frame_loss_in,
      signal_loss_in} = al;
   // ------------------------------------------------------------------
   // instances
   // ------------------------------------------------------------------
   rxa_alarm_section_ctrl rxa_alarm_section_ctrl_inst (.*);
   rxa_line_model rxa_line_model_inst (.clk(clk), .go(fr_go),
      .bad_idx(bad_idx), .bad_xor(bad_xor), .frame_boundary(fb_m),
      .fr_byte_vld(fr_byte_vld), .fr_byte(fr_byte),
      .fr_first_a1(fr_first_a1), .fr_is_a2(fr_is_a2),
      .fr_last_a2(fr_last_a2));
   // ------------------------------------------------------------------
   // tasks
   // ------------------------------------------------------------------
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'h1;
      @(posedge clk);
      reg_wr <= 1'h0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'h1;
      @(posedge clk);
      reg_rd <= 1'h0;
      @(negedge clk);
      chk(reg_rdata, exp);
   endtask
   task automatic set_al(input logic [15:0] v);
      @(posedge clk);
      al <= v;
      repeat (3) @(posedge clk);
      @(negedge clk);
   endtask
   task automatic stop_test();
      $display("checks_done=%0d fail_count=%0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0)
      begin
         $display("RESULT: PASS");
      end
      else
      begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   // ------------------------------------------------------------------
   // clock and watchdog
   // ------------------------------------------------------------------
   initial
   begin
      clk = 1'h0;
      forever #4 clk = ~clk;
   end
   initial
   begin
      // whole sequence needs about 650 cycles
      repeat (20000) @(posedge clk);
      fail_count++;
      stop_test();
   end
   // ------------------------------------------------------------------
   // tests
   // ------------------------------------------------------------------
   initial
   begin
      logic [13:0] en;
      {reg_wr, reg_rd, b1_check_vld, fb_b, rx_in_vld, fr_go} = 6'h00;
      {reg_addr, reg_wdata, b1_err_bits, rx_in_data} = 32'h0;
      {scr_keystream, bad_xor, bad_idx, al} = 35'h0;
      sys_rst = 1'h1;
      repeat (16) @(posedge clk);
      sys_rst <= 1'h0;
      rd(OFS_LINE_AIS, RST_LINE_AIS);
      rd(OFS_PATH_AIS, RST_PATH_AIS);
      rd(OFS_ROUTE1, RST_ROUTE);
      rd(OFS_ROUTE2, RST_ROUTE);
      rd(OFS_SEC_CTRL, RST_SEC_CTRL);
      rd(OFS_SEC_STAT, 8'h00);
      wr(8'h20, 8'h5a);
      rd(8'h20, 8'h00);
      // status: live, sticky on both edges, read-clear, irq enable
      wr(OFS_SEC_CTRL, 8'h07);
      for (int j = 0; j < 3; j++)
      begin
         set_al(16'h4 >> j);
         chk(section_irq, 8'h01);
         rd(OFS_SEC_STAT, (8'h01 << j) | (8'h08 << j));
         chk(section_irq, 8'h00);
         rd(OFS_SEC_STAT, 8'h01 << j);
         set_al(16'h0);
         chk(section_irq, 8'h01);
         rd(OFS_SEC_STAT, 8'h08 << j);
      end
      wr(OFS_SEC_CTRL, 8'h00);
      set_al(16'h4);
      chk(section_irq, 8'h00);
      rd(OFS_SEC_STAT, 8'h09);
      set_al(16'h0);
      rd(OFS_SEC_STAT, 8'h08);
      // section parity events, bit and block counting
      for (int k = 0; k < 4; k++)
      begin
         wr(OFS_SEC_CTRL, B1_CTL[k]);
         @(posedge clk);
         b1_err_bits <= B1_ERR[k];
         b1_check_vld <= 1'h1;
         @(posedge clk);
         b1_check_vld <= 1'h0;
         b1_err_bits <= ~B1_ERR[k];
         @(negedge clk);
         chk(b1_inc_vld, 8'h01);
         chk(b1_inc, B1_INC[k]);
         chk(block_parity_count, B1_CTL[k][7]);
         chk(section_irq, 8'h01);
         rd(OFS_SEC_STAT, 8'h40);
      end
      // path AIS: enabled pass, then disabled pass
      for (int p = 0; p < 2; p++)
      begin
         wr(OFS_LINE_AIS, p ? 8'h00 : 8'he0);
         wr(OFS_PATH_AIS, p ? 8'h00 : 8'hc8);
         for (int k = 0; k < 6; k++)
         begin
            set_al(16'h1 << SRC[k]);
            chk(path_ais_insert, !p);
            chk(force_cell_delin_loss, !p);
            set_al(16'h0);
            chk(path_ais_insert, 8'h00);
            chk(force_cell_delin_loss, 8'h00);
         end
      end
      // summary: each alarm with only its own enable missing, then all
      for (int i = 0; i < 14; i++)
      begin
         en = 14'h3fff ^ (14'h1 << i);
         wr(OFS_ROUTE2, {1'h0, en[6:0]});
         wr(OFS_ROUTE1, {en[13], 1'h0, en[12:7]});
         set_al(16'h1 << i);
         chk(alarm_summary_output, 8'h00);
         wr(OFS_ROUTE1, 8'hbf);
         wr(OFS_ROUTE2, 8'h7f);
         set_al(16'h1 << i);
         chk(alarm_summary_output, 8'h01);
         set_al(16'h0);
         chk(alarm_summary_output, 8'h00);
      end
      // framing patterns in both algorithms
      for (int k = 0; k < 8; k++)
      begin
         wr(OFS_SEC_CTRL, FR_CTL[k]);
         @(posedge clk);
         bad_idx <= FR_IDX[k];
         bad_xor <= FR_XOR[k];
         fr_go <= 1'h1;
         @(posedge clk);
         fr_go <= 1'h0;
         for (int n = 0; n < 20 && fr_check_done !== 1'h1; n++)
            @(negedge clk);
         chk(fr_check_done, 8'h01);
         chk(fr_pattern_ok, FR_OK[k]);
         chk(alt_framing_select, FR_CTL[k][4]);
      end
      // forced out of frame waits for the boundary
      wr(OFS_SEC_CTRL, 8'h20);
      repeat (3) @(negedge clk);
      chk(force_oof_pulse, 8'h00);
      @(posedge clk);
      fb_b <= 1'h1;
      @(posedge clk);
      fb_b <= 1'h0;
      @(negedge clk);
      chk(force_oof_pulse, 8'h01);
      @(negedge clk);
      chk(force_oof_pulse, 8'h00);
      // descrambling on and bypassed
      for (int k = 0; k < 2; k++)
      begin
         wr(OFS_SEC_CTRL, k ? 8'h40 : 8'h00);
         @(posedge clk);
         rx_in_vld <= 1'h1;
         rx_in_data <= 8'h5a;
         scr_keystream <= 8'h3c;
         @(posedge clk);
         rx_in_vld <= 1'h0;
         @(negedge clk);
         chk(rx_out_vld, 8'h01);
         chk(rx_out_data, k ? 8'h5a : 8'h66);
         chk(descrambler_bypass, k);
      end
      stop_test();
   end
endmodule // rxa_alarm_section_ctrl_bench
